/* src/gpb_blink_timer.sv */
`timescale 1ns/100ps
module gpb_blink_timer
   import gpb_pkg::*;
#(
   parameter int HALF_CYC = GPB_BLINK_CYC
)
(
   input logic clock,
   input logic rst_n,
   input logic clkEn,
   output logic phase
);
   localparam logic [31:0] LAST = 32'(HALF_CYC - 1);
   gpb_blink_t s_reg;
   gpb_blink_t s_next;

   // Free running, so every blinking pin shares one phase
   always_comb
   begin
      s_next = s_reg;
      if (s_reg.cnt >= LAST)
      begin
         s_next.cnt = '0;
         s_next.phase = ~s_reg.phase;
      end
      else
         s_next.cnt = s_reg.cnt + 32'h0000_0001;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         s_reg <= '0;
      else if (clkEn)
         s_reg <= s_next;
   end

   assign phase = s_reg.phase;

   halfHold_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && s_reg.cnt < LAST |=> phase == $past(phase))
      else $error("blink phase moved before half period");
   halfFlip_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && s_reg.cnt == LAST |=> phase != $past(phase))
      else $error("blink phase missed its toggle");
endmodule // gpb_blink_timer

/* src/gpb_gpio_bank.sv */
`timescale 1ns/100ps
module gpb_gpio_bank
   import gpb_pkg::*;
#(
   parameter int BLINK_HALF_CYC = GPB_BLINK_CYC
)
(
   input logic clock,
   input logic rst_n,
   input logic clkEn,
   input logic busReset,
   input logic sysResetWrite,
   input logic [GPB_ADDR_W-1:GPB_WIN_W] ioBase,
   input gpb_io_req_t ioReq,
   output logic [31:0] ioRdData,
   output logic ioRdValid,
   input logic [31:0] pinIn,
   output logic [31:0] pinOut,
   output logic [31:0] pinOe,
   output logic [31:0] pinUseGpio,
   input logic [GPB_UP_W-1:0] upIn,
   output logic [GPB_UP_W-1:0] upOut,
   output logic [GPB_UP_W-1:0] upOe,
   output logic [GPB_UP_W-1:0] upUseGpio,
   output logic [GPB_EVT_W-1:0] eventLevel
);
   gpb_state_t s_reg;
   gpb_state_t s_next;
   logic [31:0] inSync;
   logic [GPB_UP_W-1:0] upSync;
   logic blinkPhase;
   logic reqHit;
   logic [5:0] reqOfs;

   gpb_sync #(.W(32)) u_pinSync (
      .clock(clock),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .d(pinIn),
      .q(inSync)
   );

   gpb_sync #(.W(GPB_UP_W)) u_upSync (
      .clock(clock),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .d(upIn),
      .q(upSync)
   );

   gpb_blink_timer #(.HALF_CYC(BLINK_HALF_CYC)) u_blink (
      .clock(clock),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .phase(blinkPhase)
   );

   // Byte-lane merge; bits outside mask keep their stored value
   function automatic logic [31:0] wmerge(input logic [31:0] old,
      input logic [31:0] d, input logic [GPB_BYTES-1:0] be,
      input logic [31:0] mask);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < GPB_BYTES; i++)
         m[i*GPB_BYTE_W +: GPB_BYTE_W] = {GPB_BYTE_W{be[i]}};
      m = m & mask;
      return (old & ~m) | (d & m);
   endfunction

   // Input pins show the pad, output pins the stored bit
   function automatic logic [31:0] pick(input logic [31:0] dir,
      input logic [31:0] pad, input logic [31:0] lvl);
      return (dir & pad) | (~dir & lvl);
   endfunction

   function automatic logic [31:0] readReg(input logic [5:0] ofs,
      input gpb_state_t st, input logic [31:0] pad,
      input logic [GPB_UP_W-1:0] upPad);
      logic [31:0] r;
      r = '0;
      if (ofs == GPB_OFS_FUNC)
         r = (st.func & GPB_FUNC_IMPL) | GPB_FUNC_FIXED;
      else if (ofs == GPB_OFS_DIR)
         r = (st.dir & GPB_DIR_RW) | GPB_FIXED_IN;
      else if (ofs == GPB_OFS_LVL)
         r = (st.lvl & GPB_LVL_CORE)
            | (pick(st.dir, pad, st.lvl) & GPB_LVL_RES);
      else if (ofs == GPB_OFS_BUF)
         r = GPB_BUF_VAL;
      else if (ofs == GPB_OFS_BLINK)
         r = st.blink;
      else if (ofs == GPB_OFS_INV)
         r = st.inv;
      else if (ofs == GPB_OFS_FUNCU)
         r = st.funcU;
      else if (ofs == GPB_OFS_DIRU)
         r = st.dirU;
      else if (ofs == GPB_OFS_LVLU)
         r = pick(st.dirU, 32'(upPad), st.lvlU) & GPB_UP_MASK;
      return r;
   endfunction

   // Accesses outside the window belong to other decoders: no answer
   assign reqHit = (ioReq.rd || ioReq.wr)
      && ioReq.addr[GPB_ADDR_W-1:GPB_WIN_W] == ioBase;
   assign reqOfs = {ioReq.addr[GPB_WIN_W-1:2], 2'b00};

   always_comb
   begin
      s_next = s_reg;
      s_next.rdValid = 1'b0;
      if (reqHit && ioReq.wr)
      begin
         if (reqOfs == GPB_OFS_FUNC)
            s_next.func = wmerge(s_reg.func, ioReq.data, ioReq.be,
               GPB_FUNC_IMPL);
         else if (reqOfs == GPB_OFS_DIR)
            s_next.dir = wmerge(s_reg.dir, ioReq.data, ioReq.be,
               GPB_DIR_RW);
         else if (reqOfs == GPB_OFS_LVL)
            s_next.lvl = wmerge(s_reg.lvl, ioReq.data, ioReq.be,
               GPB_LVL_RES | GPB_LVL_CORE);
         else if (reqOfs == GPB_OFS_BLINK)
            s_next.blink = wmerge(s_reg.blink, ioReq.data, ioReq.be,
               GPB_BLK_RES | GPB_BLK_CORE);
         else if (reqOfs == GPB_OFS_INV)
            s_next.inv = wmerge(s_reg.inv, ioReq.data, ioReq.be,
               GPB_INV_RES | GPB_INV_CORE);
         else if (reqOfs == GPB_OFS_FUNCU)
            s_next.funcU = wmerge(s_reg.funcU, ioReq.data, ioReq.be,
               GPB_UP_MASK);
         else if (reqOfs == GPB_OFS_DIRU)
            s_next.dirU = wmerge(s_reg.dirU, ioReq.data, ioReq.be,
               GPB_UP_MASK);
         else if (reqOfs == GPB_OFS_LVLU)
            s_next.lvlU = wmerge(s_reg.lvlU, ioReq.data, ioReq.be,
               GPB_UP_MASK);
      end
      // Well resets override a write landing in the same cycle
      if (sysResetWrite)
      begin
         s_next.lvl = (s_next.lvl & ~GPB_LVL_RES)
            | (GPB_LVL_RST & GPB_LVL_RES);
         s_next.blink = s_next.blink & ~GPB_BLK_RES;
         s_next.inv = s_next.inv & ~GPB_INV_RES;
      end
      if (busReset)
      begin
         s_next.lvl = (s_next.lvl & ~GPB_LVL_CORE)
            | (GPB_LVL_RST & GPB_LVL_CORE);
         s_next.blink = s_next.blink & ~GPB_BLK_CORE;
         s_next.inv = s_next.inv & ~GPB_INV_CORE;
         s_next.funcU = '0;
         s_next.dirU = '0;
         s_next.lvlU = GPB_LVLU_RST;
      end
      if (reqHit && ioReq.rd)
      begin
         s_next.rdData = readReg(reqOfs, s_reg, inSync, upSync);
         s_next.rdValid = 1'b1;
      end
      // Pin drivers lag the registers by one cycle to stay flop-driven
      s_next.pinOe = GPB_FIXED_OUT | (~s_reg.dir & GPB_LVL_RES);
      s_next.pinOut = (s_reg.lvl ^ (s_reg.blink & {32{blinkPhase}}))
         & s_next.pinOe;
      s_next.useGpio = (s_reg.func & GPB_FUNC_IMPL) | GPB_FUNC_FIXED;
      for (int i = 0; i < GPB_PAIRS; i++)
         s_next.useGpio[GPB_GNT_BASE+i] = s_reg.func[i];
      s_next.upUse = s_reg.funcU[GPB_UP_W-1:0];
      s_next.upOe = ~s_reg.dirU[GPB_UP_W-1:0] & s_reg.funcU[GPB_UP_W-1:0];
      s_next.upOut = s_reg.lvlU[GPB_UP_W-1:0];
      // Polarity only touches inputs; all of 15:0 are fixed inputs
      s_next.evt = (inSync[GPB_EVT_W-1:0] ^ s_reg.inv[GPB_EVT_W-1:0])
         & GPB_INV_RES[GPB_EVT_W-1:0]
         | (inSync[GPB_EVT_W-1:0] ^ s_reg.inv[GPB_EVT_W-1:0])
         & GPB_INV_CORE[GPB_EVT_W-1:0];
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         s_reg <= GPB_STATE_RST;
      else if (clkEn)
         s_reg <= s_next;
   end

   assign ioRdData = s_reg.rdData;
   assign ioRdValid = s_reg.rdValid;
   assign pinOut = s_reg.pinOut;
   assign pinOe = s_reg.pinOe;
   assign pinUseGpio = s_reg.useGpio;
   assign upOut = s_reg.upOut;
   assign upOe = s_reg.upOe;
   assign upUseGpio = s_reg.upUse;
   assign eventLevel = s_reg.evt;

   readAnswer_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && reqHit && ioReq.rd |=> ioRdValid)
      else $error("window read not answered");
   outsideWin_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && !reqHit |=> !ioRdValid)
      else $error("answer given outside the window");
   funcAbsent_a: assert property (@(posedge clock) disable iff (!rst_n)
      $past(clkEn) && ioRdValid && $past(reqOfs) == GPB_OFS_FUNC
      |-> (ioRdData & GPB_FUNC_ABSENT) == '0)
      else $error("absent function-select bit read nonzero");
   pairSwitch_a: assert property (@(posedge clock) disable iff (!rst_n)
      pinUseGpio[GPB_GNT_BASE +: GPB_PAIRS]
         == pinUseGpio[GPB_PAIRS-1:0])
      else $error("grant pin not following its request pin");
   dirFixed_a: assert property (@(posedge clock) disable iff (!rst_n)
      $past(clkEn) && ioRdValid && $past(reqOfs) == GPB_OFS_DIR
      |-> ioRdData[23:0] == GPB_FIXED_IN[23:0])
      else $error("fixed direction bits read wrong");
   fixedOe_a: assert property (@(posedge clock) disable iff (!rst_n)
      (pinOe & (GPB_FIXED_OUT | GPB_FIXED_IN)) == GPB_FIXED_OUT)
      else $error("fixed pin direction changed");
   driveLevel_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && !s_reg.dir[24] |=> pinOe[24]
         && pinOut[24] == $past(s_reg.lvl[24]))
      else $error("output pin not driving its level bit");
   blinkDrive_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && !s_reg.dir[27] |=> pinOut[27] == ($past(s_reg.lvl[27])
         ^ ($past(s_reg.blink[27]) & $past(blinkPhase))))
      else $error("blinking pin value wrong");
   inputRead_a: assert property (@(posedge clock) disable iff (!rst_n)
      $past(clkEn) && ioRdValid && $past(reqOfs) == GPB_OFS_LVL
      && $past(s_reg.dir[28]) |-> ioRdData[28] == $past(inSync[28])
      && ioRdData[15:0] == '0)
      else $error("input level readback wrong");
   sysReset_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && sysResetWrite |=> (s_reg.lvl & GPB_LVL_RES)
         == (GPB_LVL_RST & GPB_LVL_RES)
         && (s_reg.blink & GPB_BLK_RES) == '0)
      else $error("reset-port write left resume bits");
   busReset_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && busReset |=> (s_reg.lvl & GPB_LVL_CORE)
         == (GPB_LVL_RST & GPB_LVL_CORE))
      else $error("bus reset left core level bits");
   coreKeep_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn && !busReset && !(reqHit && ioReq.wr)
      |=> (s_reg.lvl & GPB_LVL_CORE)
         == ($past(s_reg.lvl) & GPB_LVL_CORE))
      else $error("core level bits changed without cause");
   evtPolarity_a: assert property (@(posedge clock) disable iff (!rst_n)
      clkEn |=> eventLevel[0] == ($past(inSync[0])
         ^ $past(s_reg.inv[0])))
      else $error("event level polarity wrong");
endmodule // gpb_gpio_bank

/* src/gpb_pkg.sv */
package gpb_pkg;
   localparam int GPB_ADDR_W = 16;
   localparam int GPB_WIN_W = 6;
   localparam int GPB_UP_W = 12;
   localparam int GPB_EVT_W = 16;
   localparam int GPB_PAIRS = 2;
   localparam int GPB_GNT_BASE = 16;
   localparam int GPB_BYTES = 4;
   localparam int GPB_BYTE_W = 8;
   localparam logic [5:0] GPB_OFS_FUNC = 6'h00;
   localparam logic [5:0] GPB_OFS_DIR = 6'h04;
   localparam logic [5:0] GPB_OFS_LVL = 6'h0c;
   localparam logic [5:0] GPB_OFS_BUF = 6'h14;
   localparam logic [5:0] GPB_OFS_BLINK = 6'h18;
   localparam logic [5:0] GPB_OFS_INV = 6'h2c;
   localparam logic [5:0] GPB_OFS_FUNCU = 6'h30;
   localparam logic [5:0] GPB_OFS_DIRU = 6'h34;
   localparam logic [5:0] GPB_OFS_LVLU = 6'h38;
   localparam logic [31:0] GPB_FUNC_RST = 32'h1a00_3180;
   localparam logic [31:0] GPB_FUNC_IMPL = 32'h0020_083f;
   localparam logic [31:0] GPB_FUNC_ABSENT = 32'he400_c600;
   localparam logic [31:0] GPB_FUNC_FIXED = GPB_FUNC_RST & ~GPB_FUNC_IMPL;
   localparam logic [31:0] GPB_DIR_RW = 32'h1b00_0000;
   localparam logic [31:0] GPB_FIXED_IN = 32'h0000_ffff;
   localparam logic [31:0] GPB_FIXED_OUT = 32'h00ff_0000;
   localparam logic [31:0] GPB_LVL_RES = 32'h1b00_0000;
   localparam logic [31:0] GPB_LVL_CORE = 32'h00ff_0000;
   localparam logic [31:0] GPB_LVL_RST = 32'h1b3f_0000;
   localparam logic [31:0] GPB_BUF_VAL = 32'h0663_0000;
   localparam logic [31:0] GPB_BLK_RES = 32'h1a00_0000;
   localparam logic [31:0] GPB_BLK_CORE = 32'h000c_0000;
   localparam logic [31:0] GPB_INV_RES = 32'h0000_3900;
   localparam logic [31:0] GPB_INV_CORE = 32'h0000_00ff;
   localparam logic [31:0] GPB_UP_MASK = 32'h0000_0fff;
   localparam logic [31:0] GPB_LVLU_RST = 32'h0000_0fff;
   localparam logic [31:0] GPB_OE_RST = GPB_FIXED_OUT | GPB_LVL_RES;
   localparam logic [31:0] GPB_OUT_RST = GPB_LVL_RST & GPB_OE_RST;
   localparam int GPB_CLK_NS = 5;
   localparam longint GPB_BLINK_HALF_NS = 500_000_000;
   localparam int GPB_BLINK_CYC = int'(GPB_BLINK_HALF_NS / GPB_CLK_NS);

   typedef struct packed {
      logic [GPB_ADDR_W-1:0] addr;
      logic rd;
      logic wr;
      logic [GPB_BYTES-1:0] be;
      logic [31:0] data;
   } gpb_io_req_t;

   typedef struct packed {
      logic [31:0] func;
      logic [31:0] dir;
      logic [31:0] lvl;
      logic [31:0] blink;
      logic [31:0] inv;
      logic [31:0] funcU;
      logic [31:0] dirU;
      logic [31:0] lvlU;
      logic [31:0] rdData;
      logic rdValid;
      logic [31:0] pinOut;
      logic [31:0] pinOe;
      logic [31:0] useGpio;
      logic [GPB_UP_W-1:0] upOut;
      logic [GPB_UP_W-1:0] upOe;
      logic [GPB_UP_W-1:0] upUse;
      logic [GPB_EVT_W-1:0] evt;
   } gpb_state_t;

   localparam gpb_state_t GPB_STATE_RST = '{
      func: GPB_FUNC_RST & GPB_FUNC_IMPL, dir: '0, lvl: GPB_LVL_RST,
      blink: '0, inv: '0, funcU: '0, dirU: '0, lvlU: GPB_LVLU_RST,
      rdData: '0, rdValid: 1'b0, pinOut: GPB_OUT_RST, pinOe: GPB_OE_RST,
      useGpio: GPB_FUNC_RST, upOut: GPB_LVLU_RST[GPB_UP_W-1:0], upOe: '0,
      upUse: '0, evt: '0};

   typedef struct packed {
      logic [31:0] cnt;
      logic phase;
   } gpb_blink_t;
endpackage

/* src/gpb_sync.sv */
`timescale 1ns/100ps
module gpb_sync
   import gpb_pkg::*;
#(
   parameter int W = 32
)
(
   input logic clock,
   input logic rst_n,
   input logic clkEn,
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [1:0][W-1:0] s_reg;
   logic [1:0][W-1:0] s_next;

   // Stage 0 feeds stage 1 only
   always_comb
   begin
      s_next = {s_reg[0], d};
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         s_reg <= '0;
      else if (clkEn)
         s_reg <= s_next;
   end

   assign q = s_reg[1];
endmodule // gpb_sync

/* tb/general_purpose_io_bank_tb.sv */
`timescale 1ns/100ps
module general_purpose_io_bank_tb
   import gpb_pkg::*;
   ;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic busReset = 1'b0;
   logic sysResetWrite = 1'b0;
   logic [GPB_ADDR_W-1:GPB_WIN_W] ioBase = '0;
   gpb_io_req_t ioReq = '0;
   logic [31:0] ioRdData, pinIn, pinOut, pinOe, pinUseGpio;
   logic ioRdValid;
   logic [GPB_UP_W-1:0] upIn, upOut, upOe, upUseGpio;
   logic [GPB_EVT_W-1:0] eventLevel;
   logic [31:0] extDrive = '0;
   logic [GPB_UP_W-1:0] upExt = '0;
   logic [31:0] func, dir, lvl, blink, inv, funcU, dirU, lvlU, v;
   logic [5:0] o;
   int n;
   int fails = 0;
   int comparisons = 0;

   always #2.5 clock = ~clock;

   gpb_gpio_bank #(.BLINK_HALF_CYC(8)) dut (
      .clock(clock), .rst_n(rst_n), .clkEn(1'b1), .busReset(busReset),
      .sysResetWrite(sysResetWrite), .ioBase(ioBase), .ioReq(ioReq),
      .ioRdData(ioRdData), .ioRdValid(ioRdValid), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe(pinOe), .pinUseGpio(pinUseGpio),
      .upIn(upIn), .upOut(upOut), .upOe(upOe), .upUseGpio(upUseGpio),
      .eventLevel(eventLevel));

   gpb_pad_model pads (
      .pinOut(pinOut), .pinOe(pinOe), .upOut(upOut), .upOe(upOe),
      .extDrive(extDrive), .upExt(upExt), .pinIn(pinIn), .upIn(upIn));

   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask

   function automatic logic [31:0] mdl(input logic [5:0] a);
      logic [31:0] dm;
      logic [31:0] um;
      dm = dir & GPB_DIR_RW;
      um = dirU & GPB_UP_MASK;
      case (a)
         GPB_OFS_FUNC: return (func & GPB_FUNC_IMPL) | GPB_FUNC_FIXED;
         GPB_OFS_DIR: return dm | GPB_FIXED_IN;
         GPB_OFS_LVL: return (lvl & GPB_LVL_CORE) |
            (lvl & GPB_LVL_RES & ~dm) | (extDrive & GPB_LVL_RES & dm);
         GPB_OFS_BUF: return GPB_BUF_VAL;
         GPB_OFS_BLINK: return blink & (GPB_BLK_RES | GPB_BLK_CORE);
         GPB_OFS_INV: return inv & (GPB_INV_RES | GPB_INV_CORE);
         GPB_OFS_FUNCU: return funcU & GPB_UP_MASK;
         GPB_OFS_DIRU: return um;
         GPB_OFS_LVLU: return (lvlU & ~um | 32'(upExt) & um) & GPB_UP_MASK;
         default: return 32'h0000_0000;
      endcase
   endfunction

   // Low address bits are random since the word select ignores them
   task automatic access(input logic [5:0] a, input logic w,
      input logic [3:0] be, input logic [31:0] d, input logic hit);
      step(1);
      ioReq.addr = {hit ? ioBase : ~ioBase, a | 6'($urandom_range(3))};
      ioReq.rd = ~w;
      ioReq.wr = w;
      ioReq.be = be;
      ioReq.data = d;
      step(1);
      ioReq.rd = 1'b0;
      ioReq.wr = 1'b0;
      check("ioRdValid", 32'(ioRdValid), 32'(hit & ~w));
   endtask

   task automatic rdchk(input logic [5:0] a);
      access(a, 1'b0, 4'h0, 32'h0000_0000, 1'b1);
      check($sformatf("read %h", a), ioRdData, mdl(a));
   endtask

   task automatic wr(input logic [5:0] a, input logic [3:0] be,
      input logic [31:0] d);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      access(a, 1'b1, be, d, 1'b1);
      d = d & m;
      case (a)
         GPB_OFS_FUNC: func = (func & ~m) | d;
         GPB_OFS_DIR: dir = (dir & ~m) | d;
         GPB_OFS_LVL: lvl = (lvl & ~m) | d;
         GPB_OFS_BLINK: blink = (blink & ~m) | d;
         GPB_OFS_INV: inv = (inv & ~m) | d;
         GPB_OFS_FUNCU: funcU = (funcU & ~m) | d;
         GPB_OFS_DIRU: dirU = (dirU & ~m) | d;
         GPB_OFS_LVLU: lvlU = (lvlU & ~m) | d;
         default: ;
      endcase
   endtask

   task automatic scan();
      for (int a = 0; a < 64; a += 4)
         rdchk(6'(a));
   endtask

   // Blinking pins are left out here; their phase is free running
   task automatic pins();
      logic [31:0] oe, f, nb, uoe;
      step(2);
      oe = GPB_FIXED_OUT | (~dir & GPB_DIR_RW);
      f = (func & GPB_FUNC_IMPL) | GPB_FUNC_FIXED;
      nb = ~(blink & (GPB_BLK_RES | GPB_BLK_CORE));
      uoe = ~dirU & funcU & GPB_UP_MASK;
      check("pinOe", pinOe, oe);
      check("pinOut", pinOut & oe & nb, lvl & oe & nb);
      check("pinUseGpio", pinUseGpio,
         f | {14'h0, f[1:0], 16'h0});
      check("upOe", 32'(upOe), uoe);
      check("upOut", 32'(upOut) & uoe, lvlU & uoe);
      check("upUseGpio", 32'(upUseGpio), funcU & GPB_UP_MASK);
      check("eventLevel", 32'(eventLevel),
         (extDrive ^ inv) & 32'h0000_39ff);
   endtask

   task automatic pulse(input int k);
      step(1);
      sysResetWrite = (k == 0);
      busReset = (k == 1);
      step(1);
      sysResetWrite = 1'b0;
      busReset = 1'b0;
      if (k == 0)
      begin
         lvl |= GPB_LVL_RES;
         blink &= ~GPB_BLK_RES;
         inv &= ~GPB_INV_RES;
      end
      else
      begin
         lvl = (lvl & ~GPB_LVL_CORE) | (GPB_LVL_RST & GPB_LVL_CORE);
         blink &= ~GPB_BLK_CORE;
         inv &= ~GPB_INV_CORE;
         funcU = '0;
         dirU = '0;
         lvlU = GPB_LVLU_RST;
      end
   endtask

   initial
   begin
      void'($urandom(32'h0daa_82f3));
      ioBase = 10'($urandom);
      func = GPB_FUNC_RST;
      dir = '0;
      lvl = GPB_LVL_RST;
      blink = '0;
      inv = '0;
      funcU = '0;
      dirU = '0;
      lvlU = GPB_LVLU_RST;
      step(10);
      check("pinOe", pinOe, GPB_OE_RST);
      check("pinOut", pinOut, GPB_OUT_RST);
      check("pinUseGpio", pinUseGpio, GPB_FUNC_RST);
      rst_n = 1'b1;
      scan();
      access(GPB_OFS_DIR, 1'b0, 4'h0, 32'h0000_0000, 1'b0);
      $display("test reset done");
      repeat (80)
      begin
         o = 6'(4 * $urandom_range(15));
         extDrive = $urandom;
         upExt = 12'($urandom);
         wr(o, 4'($urandom), $urandom);
         access(o, 1'b1, 4'hf, $urandom, 1'b0);
         pins();
         rdchk(o);
      end
      $display("test random done");
      wr(GPB_OFS_BLINK, 4'hf, 32'h0200_0000);
      wr(GPB_OFS_DIR, 4'hf, 32'h0000_0000);
      wr(GPB_OFS_LVL, 4'hf, 32'h0300_0000);
      step(2);
      v = pinOut;
      n = 0;
      repeat (32)
      begin
         step(1);
         n += int'(pinOut[25] !== v[25]);
         check("steady pin 24", 32'(pinOut[24]), 32'h1);
         v = pinOut;
      end
      check("blink toggles", 32'(n), 32'h4);
      rdchk(GPB_OFS_LVL);
      $display("test blink done");
      for (int a = 0; a < 64; a += 4)
         wr(6'(a), 4'hf, 32'hffff_ffff);
      wr(GPB_OFS_LVL, 4'hf, 32'h0000_0000);
      for (int k = 0; k < 2; k++)
      begin
         pulse(k);
         scan();
         pins();
      end
      $display("test resets done");
      complete_run();
   end
endmodule // general_purpose_io_bank_tb

/* tb/gpb_pad_model.sv */
`timescale 1ns/100ps
module gpb_pad_model
   import gpb_pkg::*;
(
   input logic [31:0] pinOut,
   input logic [31:0] pinOe,
   input logic [GPB_UP_W-1:0] upOut,
   input logic [GPB_UP_W-1:0] upOe,
   input logic [31:0] extDrive,
   input logic [GPB_UP_W-1:0] upExt,
   output logic [31:0] pinIn,
   output logic [GPB_UP_W-1:0] upIn
);
   // No pulls on the board; released pads show the external value
   assign pinIn = (pinOut & pinOe) | (extDrive & ~pinOe);
   assign upIn = (upOut & upOe) | (upExt & ~upOe);
endmodule // gpb_pad_model
